/* rtl/fci_pkg.sv */
package fci_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;

   // Clock and bus timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int T_SETUP_NS    = 10;
   localparam int T_PULSE_NS    = 40;
   localparam int T_HOLD_NS     = 10;
   localparam int T_GAP_NS      = 30;
   localparam int T_ACC_NS      = 80;
   localparam logic [4:0] CYC_SETUP = 5'((T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [4:0] CYC_PULSE = 5'((T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [4:0] CYC_HOLD  = 5'((T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [4:0] CYC_GAP   = 5'((T_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [4:0] CYC_ACC   = 5'((T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // Register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;

   // Control fields
   localparam int CTRL_INSTR_LSB = 0;
   localparam int CTRL_GO_BIT    = 3;
   localparam int CTRL_CETIM_BIT = 4;
   localparam int CTRL_RSTLO_BIT = 5;
   localparam int CTRL_HVA9_BIT  = 6;
   localparam int CTRL_HVRST_BIT = 7;
   localparam logic [7:0]  CTRL_RST = 8'h00;
   localparam logic [19:0] ADDR_RST = 20'h00000;
   localparam logic [7:0]  DATA_RST = 8'h00;

   // Status fields
   localparam int ST_BUSY_BIT   = 0;
   localparam int ST_DONE_BIT   = 1;
   localparam int ST_REJECT_BIT = 2;
   localparam int ST_RB_BIT     = 3;
   localparam int ST_TOGGLE_BIT = 4;
   localparam int ST_RD_LSB     = 8;

   // Flash status bits on the data bus
   localparam int POLL_BIT             = 7;
   localparam int TOGGLE_BIT_PRIMARY   = 6;
   localparam int ERROR_BIT            = 5;
   localparam int ERASE_TIMER_BIT      = 3;
   localparam int TOGGLE_BIT_SECONDARY = 2;

   // Write cycles per instruction
   localparam logic [2:0] WR_CYC_BASIC = 3'h3;
   localparam logic [2:0] WR_CYC_PROG  = 3'h4;
   localparam logic [2:0] WR_CYC_ERASE = 3'h6;

   typedef enum logic [2:0] {
      INS_READ, INS_RDARRAY, INS_AUTOSEL, INS_PROG,
      INS_BERASE, INS_CERASE, INS_SUSPEND, INS_RESUME
   } fci_instr_t;
endpackage

/* rtl/fci_ctl_if.sv */
`timescale 1ns/1ps
interface fci_ctl_if;
   import fci_pkg::*;
   logic             startPulse;
   fci_instr_t       instr;
   logic [19:0]      opAddr;
   logic [7:0]       opData;
   logic             ceTimed;
   logic             rstLow;
   logic             hvA9;
   logic             hvRst;
   logic             busy;
   logic             donePulse;
   logic             rejectPulse;
   logic             rbLevel;
   logic             toggleSeen;
   logic [7:0]       rdData;

   modport regs (output startPulse, instr, opAddr, opData, ceTimed, rstLow, hvA9, hvRst,
                 input  busy, donePulse, rejectPulse, rbLevel, toggleSeen, rdData);
   modport seq  (input  startPulse, instr, opAddr, opData, ceTimed, rstLow, hvA9, hvRst,
                 output busy, donePulse, rejectPulse, rbLevel, toggleSeen, rdData);
endinterface

/* rtl/fci_apb_regs.sv */
`timescale 1ns/1ps
module fci_apb_regs
   import fci_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   fci_ctl_if.regs          ctl
);
   import fci_pkg::*;

   logic [7:0]  ctrl_r;
   logic [19:0] addr_r;
   logic [7:0]  data_r;
   logic        done_r;
   logic        reject_r;
   logic [31:0] prdata_r;

   wire selCtrl   = (paddr == REG_CTRL);
   wire selAddr   = (paddr == REG_ADDR);
   wire selData   = (paddr == REG_DATA);
   wire selStatus = (paddr == REG_STATUS);
   wire mapped    = selCtrl | selAddr | selData | selStatus;
   wire wrEn      = psel & penable & pwrite & mapped;
   wire setupRd   = psel & ~penable & ~pwrite;

   wire [31:0] statusWord = {16'h0000, ctl.rdData, 3'h0, ctl.toggleSeen, ctl.rbLevel,
                             reject_r, done_r, ctl.busy};
   wire [31:0] rdMux = selCtrl   ? {24'h000000, ctrl_r} :
                       selAddr   ? {12'h000, addr_r} :
                       selData   ? {24'h000000, data_r} :
                       selStatus ? statusWord : 32'h00000000;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_r;

   assign ctl.startPulse = wrEn & selCtrl & pwdata[CTRL_GO_BIT];
   assign ctl.instr      = fci_instr_t'(pwdata[CTRL_INSTR_LSB +: 3]);
   assign ctl.opAddr     = addr_r;
   assign ctl.opData     = data_r;
   assign ctl.ceTimed    = ctrl_r[CTRL_CETIM_BIT];
   assign ctl.rstLow     = ctrl_r[CTRL_RSTLO_BIT];
   assign ctl.hvA9       = ctrl_r[CTRL_HVA9_BIT];
   assign ctl.hvRst      = ctrl_r[CTRL_HVRST_BIT];

   wire clrDone   = wrEn & selStatus & pwdata[ST_DONE_BIT];
   wire clrReject = wrEn & selStatus & pwdata[ST_REJECT_BIT];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_r   <= CTRL_RST;
         addr_r   <= ADDR_RST;
         data_r   <= DATA_RST;
         done_r   <= 1'b0;
         reject_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         if (wrEn & selCtrl) ctrl_r <= pwdata[7:0] & ~(8'h01 << CTRL_GO_BIT);
         if (wrEn & selAddr) addr_r <= pwdata[19:0];
         if (wrEn & selData) data_r <= pwdata[7:0];
         // Set wins over a clear in the same cycle
         done_r   <= ctl.donePulse | (done_r & ~clrDone);
         reject_r <= ctl.rejectPulse | (reject_r & ~clrReject);
         if (setupRd) prdata_r <= rdMux;
      end
   end
endmodule

/* rtl/fci_host.sv */
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fci_host
   import fci_pkg::*;
#(
   parameter logic [19:0] UNLOCK_A1      = 20'h00001,
   parameter logic [19:0] UNLOCK_A2      = 20'h00002,
   parameter logic [7:0]  UNLOCK_D1      = 8'h11,
   parameter logic [7:0]  UNLOCK_D2      = 8'h22,
   parameter logic [7:0]  CMD_RDARRAY    = 8'h01,
   parameter logic [7:0]  CMD_AUTOSEL    = 8'h02,
   parameter logic [7:0]  CMD_PROG       = 8'h03,
   parameter logic [7:0]  CMD_ERASE      = 8'h04,
   parameter logic [7:0]  CMD_BLK_CONF   = 8'h05,
   parameter logic [7:0]  CMD_CHIP_CONF  = 8'h06,
   parameter logic [7:0]  CMD_SUSPEND    = 8'h07,
   parameter logic [7:0]  CMD_RESUME     = 8'h08
)(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [19:0]      addrIn,
   input  wire logic [7:0]  dataBusIn,
   output logic [7:0]       dataBusOut,
   output logic             dataBusOe,
   output logic             chipSelN,
   output logic             outEnN,
   output logic             writeStrobeN,
   output logic             hwResetUnprotectN,
   output logic             resetHvSelect,
   output logic             addrHvSelect,
   input  wire logic        readyBusyOd
);
   import fci_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_LOAD, S_SETUP, S_STROBE, S_HOLD, S_GAP, S_RDACC} fci_st_t;

   fci_ctl_if ctl ();

   fci_apb_regs u_regs (
      .sys_clk (sys_clk),
      .rst     (rst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .ctl     (ctl)
   );

   fci_st_t     st_r, stNxt;
   logic [4:0]  cnt_r, cntNxt;
   logic [2:0]  wrNum_r;
   fci_instr_t  instr_r;
   logic [19:0] opAddr_r;
   logic [7:0]  opData_r;
   logic        ceTimed_r;
   logic [7:0]  rdData_r;
   logic        toggle_r;
   logic        rstLow_r, hvA9_r, hvRst_r;

   wire isProg   = (instr_r == INS_PROG);
   wire isBErase = (instr_r == INS_BERASE);
   wire isErase  = isBErase | (instr_r == INS_CERASE);
   wire isRead   = (instr_r == INS_READ);
   wire [2:0] wrTotal = isProg ? WR_CYC_PROG : isErase ? WR_CYC_ERASE : WR_CYC_BASIC;

   // Instructions the flash refuses while busy
   wire needReady = (ctl.instr == INS_PROG) | (ctl.instr == INS_BERASE) |
                    (ctl.instr == INS_CERASE);
   wire accept    = ctl.startPulse & (st_r == S_IDLE) & ~(needReady & ~readyBusyOd);

   wire [7:0] cmdByte = (instr_r == INS_RDARRAY) ? CMD_RDARRAY :
                        (instr_r == INS_AUTOSEL) ? CMD_AUTOSEL :
                        isProg                   ? CMD_PROG :
                        isErase                  ? CMD_ERASE :
                        (instr_r == INS_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;

   // Cycle contents by position
   wire [19:0] cycAddr = (wrNum_r == 3'h0) ? UNLOCK_A1 :
                         (wrNum_r == 3'h1) ? UNLOCK_A2 :
                         (wrNum_r == 3'h2) ? UNLOCK_A1 :
                         (wrNum_r == 3'h3) ? (isProg ? opAddr_r : UNLOCK_A1) :
                         (wrNum_r == 3'h4) ? UNLOCK_A2 :
                         (isBErase ? opAddr_r : UNLOCK_A1);
   wire [7:0] cycData  = (wrNum_r == 3'h0) ? UNLOCK_D1 :
                         (wrNum_r == 3'h1) ? UNLOCK_D2 :
                         (wrNum_r == 3'h2) ? cmdByte :
                         (wrNum_r == 3'h3) ? (isProg ? opData_r : UNLOCK_D1) :
                         (wrNum_r == 3'h4) ? UNLOCK_D2 :
                         (isBErase ? CMD_BLK_CONF : CMD_CHIP_CONF);

   wire phaseEnd = (cnt_r == 5'h00);
   wire lastGap  = (st_r == S_GAP) & phaseEnd & (isRead | (wrNum_r == wrTotal));

   always_comb begin
      stNxt  = st_r;
      cntNxt = phaseEnd ? 5'h00 : cnt_r - 5'h01;
      unique case (st_r)
         S_IDLE: if (accept) stNxt = S_LOAD;
         S_LOAD: begin
            stNxt  = isRead ? S_RDACC : S_SETUP;
            cntNxt = isRead ? CYC_ACC - 5'h01 : CYC_SETUP - 5'h01;
         end
         S_SETUP: if (phaseEnd) begin
            stNxt  = S_STROBE;
            cntNxt = CYC_PULSE - 5'h01;
         end
         S_STROBE: if (phaseEnd) begin
            stNxt  = S_HOLD;
            cntNxt = CYC_HOLD - 5'h01;
         end
         S_HOLD, S_RDACC: if (phaseEnd) begin
            stNxt  = S_GAP;
            cntNxt = CYC_GAP - 5'h01;
         end
         S_GAP: if (phaseEnd) begin
            stNxt  = lastGap ? S_IDLE : S_SETUP;
            cntNxt = lastGap ? 5'h00 : CYC_SETUP - 5'h01;
         end
      endcase
   end

   // Pin levels for the coming state
   wire nxtWrite = (stNxt == S_SETUP) | (stNxt == S_STROBE) | (stNxt == S_HOLD);
   wire nxtRead  = (stNxt == S_RDACC);
   wire ceNxtN   = ceTimed_r ? ~((stNxt == S_STROBE) | nxtRead) : ~(nxtWrite | nxtRead);
   wire weNxtN   = ceTimed_r ? ~nxtWrite : ~(stNxt == S_STROBE);
   wire oeNxtN   = ~nxtRead;
   wire doeNxt   = (stNxt == S_STROBE) | (stNxt == S_HOLD);
   wire loadPins = (st_r != S_SETUP) & (stNxt == S_SETUP);

   assign ctl.busy        = (st_r != S_IDLE);
   assign ctl.donePulse   = lastGap;
   assign ctl.rejectPulse = ctl.startPulse & ~accept;
   assign ctl.rbLevel     = readyBusyOd;
   assign ctl.toggleSeen  = toggle_r;
   assign ctl.rdData      = rdData_r;

   assign hwResetUnprotectN = ~rstLow_r;
   assign resetHvSelect     = hvRst_r;
   assign addrHvSelect      = hvA9_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= S_IDLE;
         cnt_r <= 5'h00;
         wrNum_r <= 3'h0;
         instr_r <= INS_READ;
         opAddr_r <= 20'h00000;
         opData_r <= 8'h00;
         ceTimed_r <= 1'b0;
      end else begin
         st_r  <= stNxt;
         cnt_r <= cntNxt;
         if (accept) begin
            instr_r   <= ctl.instr;
            opAddr_r  <= ctl.opAddr;
            opData_r  <= ctl.opData;
            ceTimed_r <= ctl.ceTimed;
            wrNum_r   <= 3'h0;
         end else if (st_r == S_HOLD && phaseEnd) begin
            wrNum_r <= wrNum_r + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         chipSelN <= 1'b1;
         writeStrobeN <= 1'b1;
         outEnN <= 1'b1;
         dataBusOe <= 1'b0;
         addrIn <= 20'h00000;
         dataBusOut <= 8'h00;
      end else begin
         chipSelN     <= ceNxtN;
         writeStrobeN <= weNxtN;
         outEnN       <= oeNxtN;
         dataBusOe    <= doeNxt;
         if (loadPins) begin
            addrIn     <= cycAddr;
            dataBusOut <= cycData;
         end else if (st_r == S_LOAD && isRead) begin
            addrIn <= opAddr_r;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdData_r <= 8'h00;
         toggle_r <= 1'b0;
         rstLow_r <= 1'b0;
         hvA9_r <= 1'b0;
         hvRst_r <= 1'b0;
      end else begin
         rstLow_r <= ctl.rstLow;
         hvA9_r   <= ctl.hvA9;
         hvRst_r  <= ctl.hvRst;
         if (st_r == S_RDACC && phaseEnd) begin
            rdData_r <= dataBusIn;
            toggle_r <= rdData_r[TOGGLE_BIT_PRIMARY] ^ dataBusIn[TOGGLE_BIT_PRIMARY];
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_UNLOCK_FIRST: assert property ((st_r == S_STROBE && wrNum_r == 3'h0) |->
      (addrIn == UNLOCK_A1 && dataBusOut == UNLOCK_D1)) else $error("bad first unlock cycle");
   AST_UNLOCK_SECOND: assert property ((st_r == S_STROBE && wrNum_r == 3'h1) |->
      (addrIn == UNLOCK_A2 && dataBusOut == UNLOCK_D2)) else $error("bad second unlock cycle");
   AST_CMD_THIRD: assert property ((st_r == S_STROBE && wrNum_r == 3'h2) |->
      (dataBusOut == cmdByte && addrIn == UNLOCK_A1)) else $error("bad command cycle");
   AST_PROG_OPERANDS: assert property ((st_r == S_STROBE && wrNum_r == 3'h3 && isProg) |->
      (addrIn == opAddr_r && dataBusOut == opData_r)) else $error("bad program operands");
   AST_ERASE_CONFIRM: assert property ((st_r == S_STROBE && wrNum_r == 3'h5) |->
      (isErase && dataBusOut == (isBErase ? CMD_BLK_CONF : CMD_CHIP_CONF)))
      else $error("bad erase confirm");
   AST_WRITE_COUNT: assert property ((lastGap && !isRead) |->
      (wrNum_r == (isProg ? 3'h4 : isErase ? 3'h6 : 3'h3))) else $error("wrong write count");
   AST_NO_CONTENTION: assert property (dataBusOe |-> (outEnN && !writeStrobeN || outEnN &&
      !chipSelN && ceTimed_r || outEnN)) else $error("data driven with output enable low");
   AST_STROBE_WIDTH: assert property (($fell(writeStrobeN) && !ceTimed_r) |->
      (!writeStrobeN && !chipSelN && outEnN)[*7]) else $error("write pulse too short");
   AST_DATA_HELD: assert property (($rose(writeStrobeN) && !ceTimed_r) |->
      (dataBusOe && $stable(dataBusOut) && $stable(addrIn))) else $error("data not held");
   AST_CE_TIMED: assert property ((ceTimed_r && st_r == S_STROBE) |->
      (!writeStrobeN && !chipSelN)) else $error("chip select timed write wrong");
   AST_BUSY_REFUSE: assert property ((ctl.startPulse && needReady && !readyBusyOd) |->
      ##1 (st_r != S_LOAD)) else $error("program or erase started while busy");
   AST_READ_DONE: assert property ((st_r == S_LOAD && isRead) |->
      ##[16:17] (st_r == S_GAP)) else $error("read access time wrong");

   COV_PROG: cover property (lastGap && isProg);
   COV_BERASE: cover property (lastGap && isBErase);
   COV_READ: cover property (lastGap && isRead);
   COV_CE_TIMED: cover property (ceTimed_r && st_r == S_STROBE);
endmodule

/* verification/fci_flash_model.sv */
`timescale 1ns/1ps
module fci_flash_model #(
   parameter logic [19:0] UA1 = 20'h00001,
   parameter logic [19:0] UA2 = 20'h00002,
   parameter logic [7:0]  UD1 = 8'h11,
   parameter logic [7:0]  UD2 = 8'h22,
   parameter logic        TOP_BOOT = 1'b1,
   parameter logic [7:0]  SIG = 8'h5a // Arbitrary value
)(
   input  wire logic [19:0] addrIn,
   input  wire logic [7:0]  dataIn,
   input  wire logic        chipSelN,
   input  wire logic        outEnN,
   input  wire logic        writeStrobeN,
   input  wire logic        hwResetUnprotectN,
   input  wire logic        addrHvSelect,
   output logic [7:0]       dqOut,
   output logic             dqOe,
   output logic             rbLow
);
   localparam logic [7:0] C_AS = 8'h02, C_PG = 8'h03, C_ER = 8'h04, C_BC = 8'h05;
   localparam logic [7:0] C_CC = 8'h06, C_SU = 8'h07, C_RE = 8'h08;
   logic [7:0]  mem [0:1048575];
   logic [19:0] la;
   logic [7:0]  ld, cmd, pd;
   logic        busy = 0, susp = 0, ers = 0, asel = 0, tog = 0;
   int          cyc = 0, left = 0, progCnt = 0, eraseCnt = 0, ersBlk = -1;
   wire wrAct = !chipSelN && !writeStrobeN && outEnN;
   wire rdAct = !chipSelN && !outEnN && hwResetUnprotectN;
   function automatic logic unl(input int n);
      return (n % 3 == 1) ? (la == UA1 && ld == UD1) : (la == UA2 && ld == UD2);
   endfunction
   // Block number of an address in the top or bottom boot map
   function automatic int blkOf(input logic [19:0] a, input logic top);
      if (top) return (a[19:16] != 4'hf) ? int'(a[19:16]) :
         !a[15] ? 15 : a[14] ? 18 : a[13] ? 17 : 16;
      return (a[19:16] != 4'h0) ? int'(a[19:16]) + 3 :
         a[15] ? 3 : !a[14] ? 0 : a[13] ? 2 : 1;
   endfunction
   always @(posedge wrAct) la = addrIn;
   always @(negedge wrAct) begin
      ld = dataIn;
      cyc++;
      case (cyc)
         3: begin
            cmd = ld;
            asel = (cmd == C_AS);
            if (!(cmd inside {C_PG, C_ER}) || rbLow) begin
               if (cmd == C_SU || cmd == C_RE) susp = busy && cmd == C_SU;
               cyc = 0;
            end
         end
         4: if (cmd == C_PG) begin
            mem[la] = ld;
            pd = ld;
            progCnt++;
            if (!susp) begin
               busy = 1;
               ers = 0;
               left = 50;
            end
            cyc = 0;
         end else if (!unl(cyc)) cyc = 0;
         6: begin
            if (ld == C_BC || ld == C_CC) begin
               if (ld == C_BC) ersBlk = blkOf(la, TOP_BOOT);
               busy = 1;
               ers = 1;
               left = 200;
               eraseCnt++;
            end
            cyc = 0;
         end
         default: if (!unl(cyc)) cyc = 0;
      endcase
   end
   always #10 if (rbLow) begin
      left--;
      if (left == 0) busy = 0;
   end
   always @(negedge hwResetUnprotectN) begin
      if (busy) left = 20;
      susp = 0;
      cyc = 0;
      asel = 0;
   end
   always @(posedge rdAct) tog = ~tog;
   assign rbLow = busy && !susp;
   assign dqOe = rdAct;
   assign dqOut = rbLow ? {!ers && !pd[7], tog, 2'b00, ers, tog, 2'b00}
                : (asel || addrHvSelect) ? SIG : mem[addrIn];
endmodule

/* verification/fci_host_tb_top.sv */
`timescale 1ns/1ps
module fci_host_tb_top;
   import fci_pkg::*;
   localparam logic [7:0] SIG = 8'h5a; // Arbitrary value
   logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, dataBusOut, dqOut, floatPat = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, st;
   logic [19:0] addrIn;
   logic        pready, pslverr, dataBusOe, chipSelN, outEnN, writeStrobeN, slvErr;
   logic        hwResetUnprotectN, resetHvSelect, addrHvSelect, dqOe, rbLow;
   int          miscompares = 0, num_checks = 0;
   wire [7:0]   dataBusIn = dataBusOe ? dataBusOut : dqOe ? dqOut : floatPat;
   wire         readyBusyOd = !rbLow;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) floatPat <= floatPat + 8'h5b;
   fci_host u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .addrIn(addrIn), .dataBusIn(dataBusIn), .dataBusOut(dataBusOut),
      .dataBusOe(dataBusOe), .chipSelN(chipSelN), .outEnN(outEnN),
      .writeStrobeN(writeStrobeN), .hwResetUnprotectN(hwResetUnprotectN),
      .resetHvSelect(resetHvSelect), .addrHvSelect(addrHvSelect), .readyBusyOd(readyBusyOd));
   fci_flash_model #(.SIG(SIG)) u_flash (.addrIn(addrIn), .dataIn(dataBusIn),
      .chipSelN(chipSelN), .outEnN(outEnN), .writeStrobeN(writeStrobeN),
      .hwResetUnprotectN(hwResetUnprotectN), .addrHvSelect(addrHvSelect), .dqOut(dqOut),
      .dqOe(dqOe), .rbLow(rbLow));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic runInstr(input logic [7:0] ctrl, input logic ok);
      apb(1'b1, REG_CTRL, {24'h0, ctrl});
      apb(1'b0, REG_STATUS, 32'h0);
      for (int i = 0; i < 100 && rd[ST_BUSY_BIT] !== 1'b0; i++) apb(1'b0, REG_STATUS, 32'h0);
      st = rd;
      chk({st[ST_DONE_BIT], st[ST_REJECT_BIT]}, {ok, !ok});
      apb(1'b1, REG_STATUS, 32'h6);
   endtask
   task automatic waitReady;
      for (int i = 0; i < 300 && rd[ST_RB_BIT] !== 1'b1; i++) apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[ST_RB_BIT], 1'b1);
   endtask
   task automatic prog(input logic [19:0] a, input logic [7:0] d, input logic ce);
      int n;
      n = u_flash.progCnt;
      apb(1'b1, REG_ADDR, {12'h0, a});
      apb(1'b1, REG_DATA, {24'h0, d});
      runInstr({3'b000, ce, 4'hb}, 1'b1);
      chk(u_flash.progCnt, n + 1);
      chk(u_flash.mem[a], d);
      apb(1'b0, REG_STATUS, 32'h0);
      waitReady();
      runInstr(8'h08, 1'b1);
      chk(st[15:8], d);
   endtask
   initial begin
      #300us;
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      chk({chipSelN, outEnN, writeStrobeN, dataBusOe, hwResetUnprotectN}, 5'b11101);
      for (int a = 0; a < 16; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         chk(rd, a == 12 ? 32'h8 : 32'h0);
      end
      apb(1'b0, 8'h10, 32'h0);
      chk({slvErr, rd[7:0]}, 9'h100);
      prog(20'h12345, 8'ha5, 1'b0);
      prog(20'h00010, 8'h3c, 1'b1);
      apb(1'b1, REG_ADDR, 32'h20000);
      runInstr(8'h0c, 1'b1);
      chk(u_flash.eraseCnt, 1);
      chk(st[ST_RB_BIT], 1'b0);
      chk(u_flash.ersBlk, 2);
      chk(u_flash.blkOf(20'hfa000, 1'b1), 17);
      chk(u_flash.blkOf(20'h04000, 1'b0), 1);
      chk(u_flash.blkOf(20'h08000, 1'b0), 3);
      runInstr(8'h0b, 1'b0);
      runInstr(8'h08, 1'b1);
      chk(st[15:8] & 8'h88, 8'h08);
      runInstr(8'h08, 1'b1);
      chk(st[ST_TOGGLE_BIT], 1'b1);
      runInstr(8'h0e, 1'b1);
      chk(st[ST_RB_BIT], 1'b1);
      prog(20'h00100, 8'h77, 1'b1);
      runInstr(8'h0f, 1'b1);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[ST_RB_BIT], 1'b0);
      waitReady();
      runInstr(8'h0d, 1'b1);
      chk(u_flash.eraseCnt, 2);
      apb(1'b1, REG_CTRL, 32'h20);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[ST_RB_BIT], 1'b0);
      apb(1'b1, REG_CTRL, 32'h0);
      waitReady();
      apb(1'b1, REG_ADDR, 32'h12345);
      runInstr(8'h0a, 1'b1);
      runInstr(8'h08, 1'b1);
      chk(st[15:8], SIG);
      runInstr(8'h09, 1'b1);
      runInstr(8'h48, 1'b1);
      chk(st[15:8], SIG);
      runInstr(8'h08, 1'b1);
      chk(st[15:8], 8'ha5);
      apb(1'b1, REG_CTRL, 32'he0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'he0);
      chk({hwResetUnprotectN, addrHvSelect, resetHvSelect}, 3'b011);
      apb(1'b1, REG_CTRL, 32'h0);
      end_sim();
   end
endmodule
